// file: rtl/msc_params.svh
// msc_params.svh: offsets, field positions, reset values and counts
// assumes: byte addresses on a 12-bit apb address, one 32-bit word each
`ifndef MSC_PARAMS_SVH
`define MSC_PARAMS_SVH
// documented register words per channel
`define MSC_MODE_A0   12'h3a0
`define MSC_CTLA_A0   12'h3a4
`define MSC_MODE_A1   12'h3a8
`define MSC_CTLA_A1   12'h3ac
`define MSC_MODE_A2   12'h378
`define MSC_CTLA_A2   12'h37c
// extra words per channel: base + stride * channel
`define MSC_OWN_BASE  12'h3c0
`define MSC_OWN_STEP  12'h010
`define MSC_OFS_TX    12'h000
`define MSC_OFS_BRG   12'h004
`define MSC_OFS_RX    12'h008
`define MSC_OFS_ST    12'h00c
// reset values
`define MSC_MODE_RST  8'h00
`define MSC_CTLA_RST  8'h08
// serial_mode_register fields
`define MSC_F_CKEXT   3
`define MSC_F_STP2    4
`define MSC_F_PEVEN   5
`define MSC_F_PEN     6
`define MSC_F_INV     7
// serial_control_register_a fields
`define MSC_F_HSDIR   2
`define MSC_F_EMPTY   3
`define MSC_F_HSDIS   4
`define MSC_F_NCH     5
`define MSC_F_EDGE    6
`define MSC_F_ORDER   7
// serial_mode_field codes
`define MSC_MD_OFF    3'h0
`define MSC_MD_SYNC   3'h1
`define MSC_MD_I2C    3'h2
`define MSC_MD_A7     3'h4
`define MSC_MD_A8     3'h5
`define MSC_MD_A9     3'h6
// timing: baud ticks per asynchronous bit and the sampling tick within it
`define MSC_OVS_LAST  4'hf
`define MSC_OVS_MID   4'h7
`endif

// file: rtl/msc_pkg.sv
// msc_pkg.sv: types shared by the serial channel block
// assumes: constants come from msc_params.svh
package msc_pkg;
    typedef enum logic [1:0] {TX_IDLE, TX_ASYNC, TX_SYNC} msc_txst_t;
    typedef enum logic {RX_IDLE, RX_BUSY} msc_rxst_t;
endpackage

// file: rtl/msc_serial_channels.sv
// msc_serial_channels.sv: three independent serial channels behind an apb slave
// assumes: pins arrive unsynchronised; output enables are low while driving
//
// The implementer's own choice: register access over APB.
`timescale 1ns/1ps
`include "msc_params.svh"
module msc_serial_channels (
    // system
    input  wire logic        clk_sys,
    input  wire logic        rstn,
    // apb slave
    input  wire logic [11:0] paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // serial pins, one bit per channel
    input  wire logic [2:0]  rxdIn,
    input  wire logic [2:0]  sclkIn,
    input  wire logic [2:0]  ctsIn_n,
    output logic      [2:0]  txdOut,
    output logic      [2:0]  txdOe_n,
    output logic      [2:0]  sclkOut,
    output logic      [2:0]  sclkOe_n,
    output logic      [2:0]  rtsOut_n,
    output logic      [2:0]  hsOe_n
);
    default clocking dc @(posedge clk_sys); endclocking
    default disable iff (!rstn);

    // asynchronous frame: start bit at bit 0, idle ones fill the stop bits
    function automatic logic [12:0] frameOf(input logic [8:0] d, input logic [1:0] ws,
                                            input logic pe, input logic pev);
        logic [12:0] f;
        logic        p;
        f = 13'h1fff;
        f[0] = 1'b0;
        p = ~pev;
        for (int k = 0; k < 9; k++) begin
            if (k < 7 + int'(ws)) begin
                f[k + 1] = d[k];
                p = p ^ d[k];
            end
        end
        if (pe) begin
            f[4'(8 + int'(ws))] = p;
        end
        return f;
    endfunction

    // byte reversal for msb-first transfers; a stream operator cannot sit inside a concatenation
    function automatic logic [7:0] rev8(input logic [7:0] v);
        logic [7:0] r;
        for (int k = 0; k < 8; k++) r[k] = v[7 - k];
        return r;
    endfunction

    logic [4:0]  preCnt;
    logic [31:0] rdVec [3];
    logic [2:0]  hit;
    wire         setup = psel & ~penable;
    wire         wrDo  = psel & penable & pready & pwrite;
    wire         rdDo  = psel & penable & pready & ~pwrite;
    wire [31:0]  rdAll = rdVec[0] | rdVec[1] | rdVec[2];
    wire         tick8  = preCnt[2:0] == 3'h7;
    wire         tick32 = preCnt == 5'h1f;

    // shared prescaler feeding every channel's own baud timer
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            preCnt <= 5'h00;
        end else begin
            preCnt <= preCnt + 5'h01;
        end
    end

    // apb answer: one wait-free access phase, read data latched at setup
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready  <= setup;
            pslverr <= setup & ~|hit;
            if (setup) begin
                prdata <= pwrite ? 32'h0000_0000 : rdAll;
            end
        end
    end

    for (genvar i = 0; i < 3; i++) begin : g_ch
        localparam logic [11:0] MODE_A = (i == 0) ? `MSC_MODE_A0 : (i == 1) ? `MSC_MODE_A1 : `MSC_MODE_A2;
        localparam logic [11:0] CTLA_A = (i == 0) ? `MSC_CTLA_A0 : (i == 1) ? `MSC_CTLA_A1 : `MSC_CTLA_A2;
        localparam logic [11:0] OWN_A  = `MSC_OWN_BASE + 12'(i) * `MSC_OWN_STEP;
        localparam logic        CAP_BC  = (i != 2);
        localparam logic        CAP_SIM = (i == 2);

        logic [7:0]  modeReg, ctlReg, brg, brgCnt;
        logic [8:0]  txHold, rxBuf, rxSyn;
        logic        txEn, rxEn, txFull, txEmpty, rxFull, perF, ferF, arbLost;
        logic        baudTick, sclkLvl, txLine, lastTx, syncDone, rxPrev;
        logic [1:0]  rxS, ckS, ctS;
        logic        ckD;
        logic [12:0] sh;
        logic [3:0]  nLeft, sub, rsub, ridx;
        logic [11:0] rfr;
        logic [8:0]  rData;
        logic        pBit;
        msc_pkg::msc_txst_t txSt;
        msc_pkg::msc_rxst_t rxSt;

        // address decode
        wire hMode = paddr == MODE_A;
        wire hCtl  = paddr == CTLA_A;
        wire hTx   = paddr == OWN_A + `MSC_OFS_TX;
        wire hBrg  = paddr == OWN_A + `MSC_OFS_BRG;
        wire hRx   = paddr == OWN_A + `MSC_OFS_RX;
        wire hSt   = paddr == OWN_A + `MSC_OFS_ST;
        assign hit[i] = hMode | hCtl | hTx | hBrg | hRx | hSt;

        // mode decode; unlisted codes act as disabled
        wire [2:0] md      = modeReg[2:0];
        wire       isI2c   = md == `MSC_MD_I2C;
        wire       isSync  = (md == `MSC_MD_SYNC) | isI2c;
        wire       isAsync = (md == `MSC_MD_A7) | (md == `MSC_MD_A8) | (md == `MSC_MD_A9);
        wire [1:0] wsel    = (md == `MSC_MD_A7) ? 2'h0 : (md == `MSC_MD_A9) ? 2'h2 : 2'h1;
        wire       extClk  = modeReg[`MSC_F_CKEXT];
        wire       pe      = modeReg[`MSC_F_PEN];
        wire       inv     = modeReg[`MSC_F_INV];
        wire       open_drain_select     = ctlReg[`MSC_F_NCH];
        wire       msb     = ctlReg[`MSC_F_ORDER] & ((md == `MSC_MD_SYNC) | (md == `MSC_MD_A8));
        wire       txBusy  = txSt != msc_pkg::TX_IDLE;

        // register read view; error flags read 0 outside async
        assign rdVec[i] = hMode ? {24'h0, modeReg} :
                          hCtl  ? {24'h0, ctlReg[7:4], txEmpty, ctlReg[2:0]} :
                          hBrg  ? {24'h0, brg} :
                          hRx   ? {16'h0, rxFull, 1'b0, perF & isAsync, ferF & isAsync, 3'h0, rxBuf} :
                          hSt   ? {26'h0, rxEn, txEn, CAP_SIM, CAP_BC, txFull, arbLost} : 32'h0;

        // software-owned configuration
        always_ff @(posedge clk_sys or negedge rstn) begin
            if (!rstn) begin
                modeReg <= `MSC_MODE_RST;
                ctlReg  <= `MSC_CTLA_RST;
                brg     <= 8'h00;
                txEn    <= 1'b0;
                rxEn    <= 1'b0;
                txHold  <= 9'h1ff;
            end else if (wrDo) begin
                if (hMode) modeReg <= pwdata[7:0];
                if (hCtl) ctlReg <= pwdata[7:0];
                if (hBrg) brg <= pwdata[7:0];
                if (hTx) txHold <= pwdata[8:0];
                if (hSt) begin
                    txEn <= pwdata[4];
                    rxEn <= pwdata[5];
                end
            end
        end

        // private baud timer: counts down on each prescaled tick, reloads from the divider at zero
        wire preTick = (ctlReg[1:0] == 2'h0) ? 1'b1 : (ctlReg[1:0] == 2'h1) ? tick8 : tick32;
        always_ff @(posedge clk_sys or negedge rstn) begin
            if (!rstn) begin
                brgCnt   <= 8'h00;
                baudTick <= 1'b0;
            end else begin
                baudTick <= 1'b0;
                if (preTick) begin
                    if (brgCnt == 8'h00) begin
                        brgCnt   <= brg;
                        baudTick <= 1'b1;
                    end else begin
                        brgCnt <= brgCnt - 8'h01;
                    end
                end
            end
        end

        // pin synchronisers; only the second stage is read by logic
        always_ff @(posedge clk_sys or negedge rstn) begin
            if (!rstn) begin
                rxS <= 2'h3;
                ckS <= 2'h3;
                ctS <= 2'h3;
                ckD <= 1'b1;
            end else begin
                rxS <= {rxS[0], rxdIn[i]};
                ckS <= {ckS[0], sclkIn[i]};
                ctS <= {ctS[0], ctsIn_n[i]};
                ckD <= ckS[1];
            end
        end

        wire rxBit   = rxS[1] ^ inv;
        wire extRise = ckS[1] & ~ckD;
        wire extFall = ~ckS[1] & ckD;
        wire ctsOk   = ctlReg[`MSC_F_HSDIS] | ctlReg[`MSC_F_HSDIR] | ~ctS[1];
        wire idleLvl = ~ctlReg[`MSC_F_EDGE];
        wire intTgl  = ~extClk & baudTick & (txSt == msc_pkg::TX_SYNC);
        // launch and sample on opposite transfer clock edges
        wire launch  = extClk ? (ctlReg[`MSC_F_EDGE] ? extRise : extFall) : intTgl & (sclkLvl == idleLvl);
        wire capture = extClk ? (ctlReg[`MSC_F_EDGE] ? extFall : extRise) : intTgl & (sclkLvl != idleLvl);
        wire [8:0] dOrd = msb ? {txHold[8], rev8(txHold[7:0])} : txHold;
        wire [3:0] nAsync = 4'(9 + int'(wsel) + int'(pe) + int'(modeReg[`MSC_F_STP2]));
        wire arbSet = isI2c & (txSt == msc_pkg::TX_SYNC) & capture & lastTx & ~rxBit;

        // transmitter: loads the shifter when software data waits and the peer allows
        always_ff @(posedge clk_sys or negedge rstn) begin
            if (!rstn) begin
                txSt     <= msc_pkg::TX_IDLE;
                sh       <= 13'h1fff;
                nLeft    <= 4'h0;
                sub      <= 4'h0;
                sclkLvl  <= 1'b1;
                txLine   <= 1'b1;
                lastTx   <= 1'b1;
                txEmpty  <= 1'b1;
                txFull   <= 1'b0;
                rxSyn    <= 9'h000;
                syncDone <= 1'b0;
            end else begin
                syncDone <= 1'b0;
                case (txSt)
                    msc_pkg::TX_IDLE: begin
                        if (isAsync) txLine <= 1'b1;
                        if (!isSync) sclkLvl <= idleLvl;
                        if (txFull & txEn & ctsOk & (isAsync | isSync)) begin
                            txFull  <= 1'b0;
                            txEmpty <= 1'b0;
                            sub     <= 4'h0;
                            if (isAsync) begin
                                sh     <= frameOf(dOrd, wsel, pe, modeReg[`MSC_F_PEVEN]);
                                nLeft  <= nAsync;
                                txLine <= 1'b0;
                                txSt   <= msc_pkg::TX_ASYNC;
                            end else begin
                                sh      <= {4'hf, isI2c ? txHold[8] : 1'b1, dOrd[7:0]};
                                nLeft   <= isI2c ? 4'h9 : 4'h8;
                                sclkLvl <= idleLvl;
                                txSt    <= msc_pkg::TX_SYNC;
                            end
                        end
                    end
                    msc_pkg::TX_ASYNC: begin
                        if (baudTick) begin
                            sub <= sub + 4'h1;
                            if (sub == `MSC_OVS_LAST) begin
                                sh     <= {1'b1, sh[12:1]};
                                txLine <= sh[1];
                                nLeft  <= nLeft - 4'h1;
                                if (nLeft == 4'h1) begin
                                    txSt    <= msc_pkg::TX_IDLE;
                                    txEmpty <= 1'b1;
                                    txLine  <= 1'b1;
                                end
                            end
                        end
                        // leaving the async modes cuts the frame; the shifter counts as empty again
                        if (!isAsync) begin
                            txSt    <= msc_pkg::TX_IDLE;
                            txEmpty <= 1'b1;
                        end
                    end
                    msc_pkg::TX_SYNC: begin
                        if (intTgl) sclkLvl <= ~sclkLvl;
                        if (launch) begin
                            txLine <= sh[0];
                            lastTx <= sh[0];
                            sh     <= {1'b1, sh[12:1]};
                        end
                        if (capture) begin
                            rxSyn <= {rxBit, rxSyn[8:1]};
                            nLeft <= nLeft - 4'h1;
                            if (nLeft == 4'h1) begin
                                txSt     <= msc_pkg::TX_IDLE;
                                txEmpty  <= 1'b1;
                                syncDone <= 1'b1;
                            end
                        end
                        if (!isSync) begin
                            txSt    <= msc_pkg::TX_IDLE;
                            txEmpty <= 1'b1;
                        end
                    end
                    default: txSt <= msc_pkg::TX_IDLE;
                endcase
                // a new write wins over the load that empties the holding word
                if (wrDo & hTx) txFull <= 1'b1;
            end
        end

        // arbitration lost: only a written zero clears, a new loss wins
        always_ff @(posedge clk_sys or negedge rstn) begin
            if (!rstn) begin
                arbLost <= 1'b0;
            end else begin
                if (wrDo & hSt & ~pwdata[0]) arbLost <= 1'b0;
                if (arbSet) arbLost <= 1'b1;
            end
        end

        // received frame fields; index of the first stop bit depends on format
        wire [3:0] rLast = 4'(8 + int'(wsel) + int'(pe));
        always_comb begin
            rData = 9'h000;
            for (int k = 0; k < 9; k++) begin
                if (k < 7 + int'(wsel)) rData[k] = rfr[k + 1];
            end
            pBit = rfr[4'(8 + int'(wsel))];
        end

        wire asyncDone = (rxSt == msc_pkg::RX_BUSY) & baudTick & (rsub == `MSC_OVS_MID) & (ridx == rLast);
        wire rxStore   = asyncDone | syncDone;
        wire perSet    = asyncDone & pe & ((^{rData, pBit}) == modeReg[`MSC_F_PEVEN]);
        wire ferSet    = asyncDone & ~rxBit;
        wire [8:0] rxNew = syncDone ? (isI2c ? {rxSyn[8], rev8(rxSyn[7:0])} :
                                       msb ? {1'b0, rev8(rxSyn[8:1])} : {1'b0, rxSyn[8:1]}) :
                           msb ? {1'b0, rev8(rData[7:0])} : rData;

        // async receiver: start edge, then mid-bit samples on the baud timer
        always_ff @(posedge clk_sys or negedge rstn) begin
            if (!rstn) begin
                rxSt   <= msc_pkg::RX_IDLE;
                rsub   <= 4'h0;
                ridx   <= 4'h0;
                rfr    <= 12'h000;
                rxPrev <= 1'b1;
            end else begin
                rxPrev <= rxBit;
                case (rxSt)
                    msc_pkg::RX_IDLE: begin
                        if (isAsync & rxEn & rxPrev & ~rxBit) begin
                            rxSt <= msc_pkg::RX_BUSY;
                            rsub <= 4'h0;
                            ridx <= 4'h0;
                        end
                    end
                    msc_pkg::RX_BUSY: begin
                        if (baudTick) begin
                            rsub <= rsub + 4'h1;
                            if (rsub == `MSC_OVS_MID) begin
                                rfr[ridx] <= rxBit;
                                ridx      <= ridx + 4'h1;
                                // a glitch that is high at mid start bit is no frame
                                if (((ridx == 4'h0) & rxBit) | (ridx == rLast)) rxSt <= msc_pkg::RX_IDLE;
                            end
                        end
                        if (!isAsync) rxSt <= msc_pkg::RX_IDLE;
                    end
                    default: rxSt <= msc_pkg::RX_IDLE;
                endcase
            end
        end

        // receive buffer and flags; a new frame wins over the clearing read
        always_ff @(posedge clk_sys or negedge rstn) begin
            if (!rstn) begin
                rxBuf  <= 9'h000;
                rxFull <= 1'b0;
                perF   <= 1'b0;
                ferF   <= 1'b0;
            end else begin
                if (rdDo & hRx) begin
                    rxFull <= 1'b0;
                    perF   <= 1'b0;
                    ferF   <= 1'b0;
                end
                if (rxStore) begin
                    rxBuf  <= rxNew;
                    rxFull <= 1'b1;
                    if (perSet) perF <= 1'b1;
                    if (ferSet) ferF <= 1'b1;
                end
            end
        end

        // pin drivers; open drain only ever pulls low
        wire txV = txLine ^ inv;
        always_ff @(posedge clk_sys or negedge rstn) begin
            if (!rstn) begin
                txdOut[i]   <= 1'b1;
                txdOe_n[i]  <= 1'b1;
                sclkOut[i]  <= 1'b1;
                sclkOe_n[i] <= 1'b1;
                rtsOut_n[i] <= 1'b1;
                hsOe_n[i]   <= 1'b1;
            end else begin
                txdOut[i]   <= open_drain_select ? 1'b0 : txV;
                txdOe_n[i]  <= ~(isAsync | isSync) | (open_drain_select & txV);
                sclkOut[i]  <= open_drain_select ? 1'b0 : sclkLvl;
                sclkOe_n[i] <= ~(isSync & ~extClk) | (open_drain_select & sclkLvl);
                rtsOut_n[i] <= ~(rxEn & ~rxFull);
                hsOe_n[i]   <= ctlReg[`MSC_F_HSDIS] | ~ctlReg[`MSC_F_HSDIR];
            end
        end

        sequence rxRead_s;
            rdDo && hRx && !rxStore;
        endsequence
        sequence txEnd_s;
            txBusy ##1 !txBusy;
        endsequence
        sequence asyncIdle_s;
            (isAsync && !txBusy && !open_drain_select && $stable(modeReg)) [*3];
        endsequence

        rxerr_clear_a: assert property (rxRead_s |=> !perF && !ferF)
            else $error("error flags survive a receive buffer read");
        arb_w1_keep_a: assert property (wrDo && hSt && pwdata[0] && !arbSet |=> arbLost == $past(arbLost))
            else $error("writing one changed arbitration lost");
        arb_w0_clr_a: assert property (wrDo && hSt && !pwdata[0] && !arbSet |=> !arbLost)
            else $error("writing zero did not clear arbitration lost");
        err_async_only_a: assert property ((perSet || ferSet) |-> isAsync)
            else $error("error flag set outside async mode");
        busy_not_empty_a: assert property (txBusy |-> !txEmpty)
            else $error("empty flag high while shifting");
        empty_after_a: assert property (txEnd_s |-> txEmpty)
            else $error("empty flag late after last bit");
        hs_off_a: assert property (ctlReg[`MSC_F_HSDIS] |=> hsOe_n[i])
            else $error("handshake pin driven while disabled");
        idle_pol_a: assert property (asyncIdle_s |-> txdOut[i] == !inv)
            else $error("idle line level ignores polarity");
    end
endmodule

// file: test/msc_peer.sv
// msc_peer.sv: serial peer on channel 0, 8-bit frames, one stop bit
// assumes: one bit lasts 16 system clocks (divider 0, prescale undivided)
`timescale 1ns/1ps
module msc_peer (
    // clock and line
    input  wire logic clk,
    input  wire logic txd,
    output logic      rxd
);
    logic [7:0] got;
    int         frames = 0;
    initial rxd = 1'b1;
    // send one frame; a zero stop bit makes a framing fault on purpose
    task automatic send(input logic [7:0] d, input logic stopBit);
        rxd <= 1'b0;
        repeat (16) @(posedge clk);
        for (int k = 0; k < 8; k++) begin
            rxd <= d[k]; // lsb first
            repeat (16) @(posedge clk);
        end
        rxd <= stopBit;
        repeat (16) @(posedge clk);
        rxd <= 1'b1;
        repeat (16) @(posedge clk);
    endtask
    // capture from mid-bit samples; a short start glitch is ignored
    always begin
        @(negedge txd);
        repeat (8) @(posedge clk);
        if (txd === 1'b0) begin
            for (int k = 0; k < 8; k++) begin
                repeat (16) @(posedge clk);
                got[k] = txd;
            end
            repeat (16) @(posedge clk);
            frames++;
        end
    end
endmodule

// file: test/testbench.sv
// testbench.sv: register and serial-frame checks of the three-channel block
// assumes: msc_peer on channel 0; channel 1 looped back on an external clock; channel 2 idle
`timescale 1ns/1ps
`include "msc_params.svh"
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin bad_count++; \
    $display("[ERR] %s expected %h seen %h", n, e, g); end end
module testbench;
    logic clk_sys = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, inv = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic pready, pslverr, err, peerRxd;
    logic [2:0] txdOut, txdOe_n, sclkOut, sclkOe_n, rtsOut_n, hsOe_n;
    logic lclk = 1'b1; // channel 1 external transfer clock, idle high
    int bad_count = 0, check_count = 0, cycles = 0;
    logic [11:0] modeA [3] = '{12'h3a0, 12'h3a8, 12'h378};
    logic [2:0] codes [6] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h5, 3'h6};
    logic [7:0] pat [2] = '{8'ha5, 8'h3c};
    msc_serial_channels msc_serial_channels_i (.clk_sys(clk_sys), .rstn(rstn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .rxdIn({1'b1, txdOut[1], peerRxd ^ inv}), .sclkIn({1'b0, lclk, 1'b0}), .ctsIn_n(3'h7), .txdOut(txdOut),
        .txdOe_n(txdOe_n), .sclkOut(sclkOut), .sclkOe_n(sclkOe_n), .rtsOut_n(rtsOut_n), .hsOe_n(hsOe_n));
    msc_peer msc_peer_i (.clk(clk_sys), .txd(txdOut[0] ^ inv), .rxd(peerRxd));
    initial forever #4 clk_sys = ~clk_sys;
    // one apb transfer; held until pready is seen high at an edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        psel <= 1'b1; penable <= 1'b0; paddr <= a; pwrite <= wr; pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do @(posedge clk_sys); while (pready !== 1'b1);
        q = prdata; err = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // hang guard: the whole run needs under two thousand cycles
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            end_of_test();
        end
    end
    initial begin
        repeat (12) @(posedge clk_sys);
        rstn <= 1'b1;
        for (int c = 0; c < 3; c++) begin
            apb(1'b0, modeA[c], 0); `CHK("mode reset", 32'h00, q)
            apb(1'b0, modeA[c] + 12'h4, 0); `CHK("ctl reset", 32'h08, q)
        end
        apb(1'b0, 12'h000, 0); `CHK("unmapped err", 1'b1, err)
        $display("reset and map test done");
        for (int i = 0; i < 6; i++) begin
            apb(1'b1, 12'h3a8, {29'h0, codes[i]});
            apb(1'b0, 12'h3a8, 0); `CHK("mode code", {29'h0, codes[i]}, q)
        end
        $display("mode code test done");
        apb(1'b1, 12'h3c4, 0);
        apb(1'b1, 12'h3cc, 32'h30);
        apb(1'b1, 12'h3a4, 32'h10); // handshake off, prescale undivided
        for (int v = 0; v < 2; v++) begin
            apb(1'b1, 12'h3a0, v ? 32'h85 : 32'h05);
            inv <= v[0];
            repeat (24) @(posedge clk_sys);
            apb(1'b1, 12'h3c0, {24'h0, pat[v]});
            apb(1'b0, 12'h3a4, 0); `CHK("empty busy", 32'h10, q)
            wait (msc_peer_i.frames == v + 1);
            `CHK("tx byte", pat[v], msc_peer_i.got)
            repeat (24) @(posedge clk_sys);
            apb(1'b0, 12'h3a4, 0); `CHK("empty done", 32'h18, q)
            `CHK("pins", 5'h13, {hsOe_n[0], rtsOut_n[0], txdOe_n[0], sclkOe_n[0], sclkOut[0]})
            msc_peer_i.send(~pat[v], 1'b1);
            apb(1'b0, 12'h3c8, 0); `CHK("rx byte", {16'h0, 8'h80, ~pat[v]}, q)
            apb(1'b0, 12'h3c8, 0); `CHK("rx cleared", 4'h0, q[15:12])
            $display("frame test done");
        end
        apb(1'b1, 12'h3a0, 32'h05);
        inv <= 1'b0;
        repeat (24) @(posedge clk_sys);
        msc_peer_i.send(8'h11, 1'b0);
        apb(1'b0, 12'h3c8, 0); `CHK("framing set", 4'h9, q[15:12])
        apb(1'b0, 12'h3c8, 0); `CHK("framing read", 4'h0, q[15:12])
        $display("framing test done");
        apb(1'b1, 12'h3a4, 32'h90); // msb first, handshake off
        apb(1'b1, 12'h3a0, 32'h65); // async 8 bits, even parity
        apb(1'b1, 12'h3c0, 32'h12);
        wait (msc_peer_i.frames == 3);
        `CHK("msb tx", 8'h48, msc_peer_i.got)
        repeat (40) @(posedge clk_sys);
        msc_peer_i.send(8'h11, 1'b1); // the idle-high stop lands in the parity slot
        apb(1'b0, 12'h3c8, 0); `CHK("parity set", 32'ha088, q)
        apb(1'b1, 12'h3a4, 32'h04); // handshake on, pin as request-to-send
        repeat (2) @(posedge clk_sys);
        `CHK("rts pin", 2'h0, {hsOe_n[0], rtsOut_n[0]})
        apb(1'b1, 12'h3a4, 32'h00); // clear-to-send input, held inactive by the bench
        apb(1'b1, 12'h3c0, 32'h12);
        repeat (20) @(posedge clk_sys);
        apb(1'b0, 12'h3a4, 0); `CHK("cts holds tx", 32'h08, q)
        $display("format and handshake test done");
        apb(1'b1, 12'h37c, 32'h10); // channel 2 async runs without handshake
        apb(1'b1, 12'h378, 32'h05); // channel 2 stays on its internal clock
        apb(1'b0, 12'h3ec, 0); `CHK("ch2 caps", 2'h2, q[3:2])
        apb(1'b0, 12'h3cc, 0); `CHK("ch0 caps", 2'h1, q[3:2])
        apb(1'b1, 12'h3ac, 32'h10); // edge select 0, handshake off
        apb(1'b1, 12'h3a8, 32'h09); // clock-synchronous on the external clock
        apb(1'b1, 12'h3dc, 32'h10); // transmit enable
        apb(1'b1, 12'h3d0, 32'h5a); // looped back from transmit to receive
        repeat (16) #62.5 lclk <= ~lclk;
        repeat (8) @(posedge clk_sys);
        apb(1'b0, 12'h3d8, 0); `CHK("sync loop", 32'h805a, q)
        apb(1'b0, 12'h3ac, 0); `CHK("sync empty", 32'h18, q)
        $display("caps and sync test done");
        end_of_test();
    end
endmodule
